// File: bond_pkg.sv
// Shared constants, configuration and bus layouts for the lane bonding logic.
// Assumes one receive user clock; all configuration is static per link.
// Functional notes
// (RL1) Alignment only moves elastic buffer pointers; data is never altered.
// (RL2) Elastic buffer must stay in use whenever bonding is used.
// (RL3) Exactly one master per bonded group; any number of followers.
// (RL4) Master select high on master, follower select high on followers.
// (RL5) Master and follower select are never both high on one lane.
// (RL6) Master control output reaches every follower, directly or chained.
// (RL7) Only lanes of one physical column are bonded together.
// (RL8) Follower control output is a pipeline stage; 3-bit level sets delay.
// (RL9) Level assignment: master 7, each follower one below its driver.
// (RL10) Then subtract lowest follower level from all lanes.
// (RL11) With 4-byte internal width, master level must not exceed 3.
// (RL12) Control buses live in the receive user clock domain.
// (RL13) No limit on lanes sharing one chain level.
// (RL14) Match sequence one; length picks subsequences, values supply them.
// (RL15) Sequence two also triggers when its option is on.
// (RL16) Compared bits depend on data width and decoded or raw source.
// (RL17) Disparity bit 9 ignored unless disparity matching is on.
// (RL18) Masked-off subsequence always counts as matched.
// (RL19) Master delays its bonding command after detecting a sequence.
// (RL20) That delay equals the programmed skew wait in user clock cycles.
// (RL21) Skew wait lies 1..14 and below half the sequence spacing.
// (RL22) Simultaneous events: correction wins if priority set, else bonding.
// (RL23) Bonding acts only while the bonding enable input is high.
// (RL24) Follower moves read pointer so its sequence reads with the master's.
package bond_pkg;
  localparam int PTR_W = 6;
  localparam int SUB_W = 10;
  localparam int SEQ_N = 4;
  localparam int LVL_W = 3;
  localparam int SKEW_W = 4;
  localparam int CTRL_W = 5;
  localparam int CTRL_BOND = 0;
  localparam int CTRL_CC = 1;
  localparam int CTRL_SKIP = 2;
  localparam int DISP_BIT = 9;
  localparam logic [SKEW_W-1:0] SKEW_MIN = 4'h1;
  localparam logic [SKEW_W-1:0] SKEW_MAX = 4'hE;
  localparam logic [LVL_W-1:0] LVL_MAX_4B = 3'h3;
  localparam logic [SUB_W-1:0] MASK_DECODED = 10'h1FF;
  localparam logic [SUB_W-1:0] MASK_RAW_10B = 10'h3FF;
  localparam logic [SUB_W-1:0] MASK_RAW_8B = 10'h0FF;
  localparam logic [PTR_W-1:0] PTR_ONE = 6'h01;
  localparam logic [PTR_W-1:0] PTR_TWO = 6'h02;

  typedef logic [SEQ_N-1:0][SUB_W-1:0] bond_seq_t;

  typedef struct packed {
    logic [2:0] bond_sequence_length;
    bond_seq_t bond_sequence_one_values;
    bond_seq_t bond_sequence_two_values;
    logic [SEQ_N-1:0] bond_sequence_one_mask;
    logic [SEQ_N-1:0] bond_sequence_two_mask;
    logic bond_sequence_two_active;
    logic bond_data_source_select;
    logic rx_width_10b;
    logic disparity_error_match_on;
    logic [SKEW_W-1:0] bond_skew_wait;
    logic correction_over_bonding_priority;
    logic rx_internal_width_sel;
  } bond_cfg_t;

  typedef struct packed {
    logic req;
    logic skip;
  } cc_evt_t;

  // Bits of a subsequence that take part in a compare
  function automatic logic [SUB_W-1:0] active_bits(input bond_cfg_t c);
    logic [SUB_W-1:0] m;
    m = c.bond_data_source_select ? MASK_DECODED :
        (c.rx_width_10b ? MASK_RAW_10B : MASK_RAW_8B);
    if (c.disparity_error_match_on)
      m[DISP_BIT] = m[DISP_BIT] | c.bond_data_source_select;
    else
      m[DISP_BIT] = 1'b0;
    return m;
  endfunction
endpackage

// File: bond_seq_match.sv
// Bonding sequence detector over the incoming symbol stream.
// Assumes one symbol per valid cycle from the receive user clock domain.
`timescale 1ns/1ns
module bond_seq_match (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [bond_pkg::SUB_W-1:0] sym_i,
  input wire logic sym_valid_i,
  input wire bond_pkg::bond_cfg_t cfg_i,
  output logic hit_o
);
  import bond_pkg::*;

  typedef struct packed {
    bond_seq_t hist;
    logic hit;
  } match_st_t;

  match_st_t st_reg;
  match_st_t st_next;

  // Oldest symbol of the window pairs with subsequence one
  function automatic logic seq_hit(input bond_seq_t h, input bond_seq_t v,
                                   input logic [SEQ_N-1:0] en,
                                   input bond_cfg_t c);
    logic ok;
    logic [SUB_W-1:0] am;
    int n;
    ok = 1'b1;
    am = active_bits(c); // RL16 RL17
    n = int'(c.bond_sequence_length);
    for (int k = 0; k < SEQ_N; k++) begin
      if (k < n && en[k]) begin // RL18
        if (((h[n-1-k] ^ v[k]) & am) != '0)
          ok = 1'b0;
      end
    end
    return ok;
  endfunction

  always_comb begin
    logic h1;
    logic h2;
    h1 = 1'b0;
    h2 = 1'b0;
    st_next = st_reg;
    st_next.hit = 1'b0;
    if (sym_valid_i) begin
      st_next.hist = {st_reg.hist[SEQ_N-2:0], sym_i};
      h1 = seq_hit(st_next.hist, cfg_i.bond_sequence_one_values,
                   cfg_i.bond_sequence_one_mask, cfg_i); // RL14
      h2 = cfg_i.bond_sequence_two_active &&
           seq_hit(st_next.hist, cfg_i.bond_sequence_two_values,
                   cfg_i.bond_sequence_two_mask, cfg_i); // RL15
      st_next.hit = h1 | h2;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hit_o = st_reg.hit;
endmodule

// File: rx_lane_channel_bonding.sv
// Receive lane bonding: sequence detect, skew wait, chained control bus and
// read pointer steering of the lane elastic buffer.
// Assumes the buffer itself sits outside; all ports share clk_i.
`timescale 1ns/1ns
module rx_lane_channel_bonding (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire bond_pkg::bond_cfg_t cfg_i,
  input wire logic bond_master_select_i,
  input wire logic bond_follower_select_i,
  input wire logic bond_enable_in_i,
  input wire logic [bond_pkg::LVL_W-1:0] bond_pipeline_level_i,
  input wire logic [bond_pkg::CTRL_W-1:0] bond_ctrl_in_i,
  input wire logic [bond_pkg::SUB_W-1:0] rx_sym_i,
  input wire logic rx_sym_valid_i,
  input wire logic [bond_pkg::PTR_W-1:0] wr_ptr_i,
  input wire logic rd_en_i,
  input wire bond_pkg::cc_evt_t cc_evt_i,
  output logic [bond_pkg::CTRL_W-1:0] bond_ctrl_out_o,
  output logic [bond_pkg::PTR_W-1:0] rd_ptr_o,
  output logic bond_done_o,
  output logic bond_wait_o,
  output logic cfg_err_o
);
  import bond_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] seq_ptr;
    logic seq_seen;
    logic waiting;
    logic [SKEW_W-1:0] wait_cnt;
    logic act_pend;
    logic [LVL_W-1:0] act_cnt;
    logic bond_hold;
    cc_evt_t cc_hold;
    logic [CTRL_W-1:0] ctrl_out;
    logic [PTR_W-1:0] rd_ptr;
    logic done;
    logic cfg_err;
  } bond_st_t;

  bond_st_t st_reg;
  bond_st_t st_next;
  logic seq_hit;

  bond_seq_match u_match (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .sym_i(rx_sym_i),
    .sym_valid_i(rx_sym_valid_i),
    .cfg_i(cfg_i),
    .hit_o(seq_hit)
  );

  // Read pointer after one cycle, with a correction event folded in
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
                                                input logic en,
                                                input cc_evt_t cc);
    logic [PTR_W-1:0] r;
    r = p;
    if (en) begin
      if (cc.req)
        r = cc.skip ? p + PTR_TWO : p;
      else
        r = p + PTR_ONE;
    end
    return r;
  endfunction

  always_comb begin
    logic is_master;
    logic is_follower;
    logic active;
    logic issue;
    logic trig;
    logic fire;
    logic bond_now;
    cc_evt_t cc_now;
    cc_evt_t cc_src;
    logic [PTR_W-1:0] first_ptr;

    is_master = 1'b0;
    is_follower = 1'b0;
    active = 1'b0;
    bond_now = 1'b0;
    cc_now = '0;
    first_ptr = '0;
    st_next = st_reg;
    issue = 1'b0;
    trig = 1'b0;
    fire = 1'b0;
    cc_src = '0;

    // Both selects high is illegal; the lane then stays passive
    is_master = bond_master_select_i & ~bond_follower_select_i;
    is_follower = bond_follower_select_i & ~bond_master_select_i;
    active = bond_enable_in_i & (is_master | is_follower); // RL23

    st_next.cfg_err = (bond_master_select_i & bond_follower_select_i) |
                      (is_master & cfg_i.rx_internal_width_sel &
                       (bond_pipeline_level_i > LVL_MAX_4B)) |
                      (is_master & ((cfg_i.bond_skew_wait < SKEW_MIN) |
                       (cfg_i.bond_skew_wait > SKEW_MAX)));

    // Write pointer is delayed to line up with the registered hit
    st_next.wr_ptr_q = wr_ptr_i;
    first_ptr = st_reg.wr_ptr_q -
                (PTR_W'(cfg_i.bond_sequence_length) - PTR_ONE);

    // Every active lane remembers where its own latest sequence starts
    if (seq_hit && active) begin
      st_next.seq_ptr = first_ptr;
      st_next.seq_seen = 1'b1;
    end

    // Master: hold back the command for the skew wait
    if (is_master && active) begin
      if (st_reg.waiting) begin
        if (st_reg.wait_cnt <= SKEW_MIN) begin // RL20
          st_next.waiting = 1'b0;
          st_next.wait_cnt = '0;
          issue = 1'b1;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt - SKEW_MIN;
        end
      end else if (seq_hit) begin
        st_next.waiting = 1'b1; // RL19
        st_next.wait_cnt = cfg_i.bond_skew_wait;
      end
    end else begin
      st_next.waiting = 1'b0;
      st_next.wait_cnt = '0;
    end

    // Control bus: master originates, follower adds one register stage
    if (is_master) begin
      cc_src = cc_evt_i;
      trig = issue;
      st_next.ctrl_out = '0;
      st_next.ctrl_out[CTRL_BOND] = issue & active;
      st_next.ctrl_out[CTRL_CC] = cc_evt_i.req;
      st_next.ctrl_out[CTRL_SKIP] = cc_evt_i.req & cc_evt_i.skip;
    end else if (is_follower) begin
      cc_src.req = bond_ctrl_in_i[CTRL_CC];
      cc_src.skip = bond_ctrl_in_i[CTRL_SKIP];
      trig = bond_ctrl_in_i[CTRL_BOND] & active;
      st_next.ctrl_out = bond_ctrl_in_i; // RL8 RL12
    end else begin
      st_next.ctrl_out = '0;
    end

    // Each lane waits its level, so all lanes act in the same cycle
    if (trig) begin
      if (bond_pipeline_level_i == '0) begin
        fire = 1'b1;
        st_next.act_pend = 1'b0;
      end else begin
        st_next.act_pend = 1'b1; // RL8
        st_next.act_cnt = bond_pipeline_level_i; // RL13
      end
    end else if (st_reg.act_pend) begin
      if (st_reg.act_cnt <= 3'h1) begin
        fire = 1'b1;
        st_next.act_pend = 1'b0;
        st_next.act_cnt = '0;
      end else begin
        st_next.act_cnt = st_reg.act_cnt - 3'h1;
      end
    end
    // Level count delays each lane so its action meets the master's slot

    // Arbitration against clock correction; the loser waits one cycle
    bond_now = (fire & st_reg.seq_seen & active) | st_reg.bond_hold;
    cc_now.req = cc_src.req | st_reg.cc_hold.req;
    cc_now.skip = st_reg.cc_hold.req ? st_reg.cc_hold.skip : cc_src.skip;
    st_next.bond_hold = 1'b0;
    st_next.cc_hold = '0;
    st_next.done = 1'b0;

    if (bond_now && cc_now.req) begin
      if (cfg_i.correction_over_bonding_priority) begin // RL22
        st_next.bond_hold = 1'b1;
        st_next.rd_ptr = ptr_step(st_reg.rd_ptr, rd_en_i, cc_now);
      end else begin
        st_next.cc_hold = cc_now;
        st_next.rd_ptr = st_reg.seq_ptr;
        st_next.done = 1'b1;
      end
    end else if (bond_now) begin
      // Sequence start becomes the next read address
      st_next.rd_ptr = st_reg.seq_ptr; // RL1 RL24
      st_next.done = 1'b1;
    end else begin
      st_next.rd_ptr = ptr_step(st_reg.rd_ptr, rd_en_i, cc_now); // RL1
    end

    if (!active) begin
      st_next.seq_seen = 1'b0;
      st_next.act_pend = 1'b0;
      st_next.bond_hold = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bond_ctrl_out_o = st_reg.ctrl_out;
  assign rd_ptr_o = st_reg.rd_ptr;
  assign bond_done_o = st_reg.done;
  assign bond_wait_o = st_reg.waiting;
  assign cfg_err_o = st_reg.cfg_err;
endmodule

// File: rx_lane_bond_properties.sv
// Concurrent checks on the ports of the lane bonding block.
// Assumes one clock domain and configuration held static between resets.
`timescale 1ns/1ns
module rx_lane_bond_props
  import bond_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire bond_pkg::bond_cfg_t cfg_i,
  input wire logic bond_master_select_i,
  input wire logic bond_follower_select_i,
  input wire logic bond_enable_in_i,
  input wire logic [bond_pkg::LVL_W-1:0] bond_pipeline_level_i,
  input wire logic [bond_pkg::CTRL_W-1:0] bond_ctrl_in_i,
  input wire logic [bond_pkg::CTRL_W-1:0] bond_ctrl_out_o,
  input wire logic bond_done_o,
  input wire logic bond_wait_o,
  input wire logic cfg_err_o
);
  logic [4:0] wait_cnt_reg;
  logic m_only;
  logic m_act;
  logic bad_cfg;
  assign m_only = bond_master_select_i && !bond_follower_select_i;
  assign m_act = m_only && bond_enable_in_i;
  // Skew range is only judged on the master lane
  assign bad_cfg = (bond_master_select_i && bond_follower_select_i) ||
    (m_only && (cfg_i.bond_skew_wait < SKEW_MIN ||
     cfg_i.bond_skew_wait > SKEW_MAX)) ||
    (m_only && cfg_i.rx_internal_width_sel &&
     bond_pipeline_level_i > LVL_MAX_4B);
  // Length of the current wait, compared against the setting when it ends
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) wait_cnt_reg <= 5'h00;
    else if (bond_wait_o) wait_cnt_reg <= wait_cnt_reg + 5'h01;
    else wait_cnt_reg <= 5'h00;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  skew_count_a: assert property ($fell(bond_wait_o) && $past(m_act) |->
    bond_ctrl_out_o[CTRL_BOND] && wait_cnt_reg == {1'b0, cfg_i.bond_skew_wait})
    else $error("bond command not issued after the skew wait");
  wait_master_a: assert property (bond_wait_o |-> $past(m_act))
    else $error("skew wait running on a lane that is not master");
  follower_pipe_a: assert property ($past(nrst_i) &&
    $past(bond_follower_select_i) && !$past(bond_master_select_i) |->
    bond_ctrl_out_o == $past(bond_ctrl_in_i))
    else $error("follower control output is not a one stage copy");
  pulse_single_a: assert property (bond_ctrl_out_o[CTRL_BOND] && m_only
    |=> !bond_ctrl_out_o[CTRL_BOND])
    else $error("bond command longer than one cycle");
  enable_gate_a: assert property ($past(nrst_i) &&
    !$past(bond_enable_in_i) && $past(m_only) |-> !bond_ctrl_out_o[CTRL_BOND])
    else $error("bond command issued while bonding disabled");
  done_single_a: assert property (bond_done_o |=> !bond_done_o)
    else $error("bond done longer than one cycle");
  bad_cfg_a: assert property ($past(nrst_i) && bad_cfg |=> cfg_err_o)
    else $error("illegal setup not flagged");
  good_cfg_a: assert property ($past(nrst_i) && !bad_cfg |=> !cfg_err_o)
    else $error("legal setup flagged as error");
  cover property (bond_ctrl_out_o[CTRL_BOND] && m_only);
  cover property (bond_done_o && bond_follower_select_i);
  cover property (cfg_err_o);
endmodule
bind rx_lane_channel_bonding rx_lane_bond_props props_u (.clk_i, .nrst_i,
  .cfg_i, .bond_master_select_i, .bond_follower_select_i, .bond_enable_in_i,
  .bond_pipeline_level_i, .bond_ctrl_in_i, .bond_ctrl_out_o, .bond_done_o,
  .bond_wait_o, .cfg_err_o);

// File: bond_upstream_model.sv
// Upstream sibling lane driving the bonding control bus of the lane.
// Assumes it shares clk_i; a delay of zero answers promptly.
`timescale 1ns/1ns
module bond_upstream_model
  import bond_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic fire_i,
  input wire logic [3:0] delay_i,
  output logic [bond_pkg::CTRL_W-1:0] bond_ctrl_o
);
  logic [4:0] cnt_reg;
  // Registered on the user clock like a real sibling output
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 5'h00;
      bond_ctrl_o <= '0;
    end else begin
      bond_ctrl_o <= '0;
      if (fire_i) cnt_reg <= {1'b0, delay_i} + 5'h01;
      else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
      if (cnt_reg == 5'h01) bond_ctrl_o[CTRL_BOND] <= 1'b1;
    end
  end
endmodule

// File: rx_lane_channel_bonding_tb.sv
// Self-checking bench: one lane as master or follower, sibling upstream.
// Assumes the checker is bound separately; 100 MHz clock.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module rx_lane_channel_bonding_tb;
  import bond_pkg::*;
  localparam logic [9:0] S1 = 10'h17C;
  localparam logic [9:0] S2 = 10'h0F7;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  bond_cfg_t cfg, c0;
  logic ms = 1'b1, fs = 1'b0, en = 1'b1, sv = 1'b0, fire = 1'b0;
  logic rd = 1'b1;
  cc_evt_t cc = '0;
  logic [2:0] lvl = 3'h0;
  logic [3:0] fdly = 4'h0;
  logic [9:0] sym = 10'h000;
  logic [5:0] wp = 6'h00, rdp;
  logic [CTRL_W-1:0] up_ctrl, outc;
  logic done, wt, err;
  int err_total = 0, checked = 0, cyc = 0;
  bond_upstream_model up_u (.clk_i, .nrst_i, .fire_i(fire), .delay_i(fdly),
    .bond_ctrl_o(up_ctrl));
  rx_lane_channel_bonding dut_u (.clk_i, .nrst_i, .cfg_i(cfg),
    .bond_master_select_i(ms), .bond_follower_select_i(fs),
    .bond_enable_in_i(en), .bond_pipeline_level_i(lvl),
    .bond_ctrl_in_i(up_ctrl), .rx_sym_i(sym), .rx_sym_valid_i(sv),
    .wr_ptr_i(wp), .rd_en_i(rd), .cc_evt_i(cc),
    .bond_ctrl_out_o(outc),
    .rd_ptr_o(rdp), .bond_done_o(done), .bond_wait_o(wt), .cfg_err_o(err));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic results();
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic rst();
    nrst_i = 1'b0;
    step();
    nrst_i = 1'b1;
    step();
  endtask
  task automatic send(input logic [9:0] s, input logic [5:0] p);
    sym = s;
    wp = p;
    sv = 1'b1;
    step();
  endtask
  task automatic m_run(input bond_cfg_t c, input logic [9:0] s0, s1,
                       input logic exp);
    cfg = c;
    rst();
    send(s0, 6'h10);
    if (c.bond_sequence_length == 3'h2) send(s1, 6'h11);
    sv = 1'b0;
    step();
    `CHK(wt, exp)
    repeat (c.bond_skew_wait) step();
    `CHK(outc[CTRL_BOND], exp)
    step();
    `CHK(done, exp)
    if (exp) `CHK(rdp, 6'h10)
  endtask
  task automatic t_master();
    bond_cfg_t c;
    logic [3:0] ws [3] = '{4'h1, 4'h3, 4'hE};
    ms = 1'b1;
    lvl = 3'h1;
    c = c0;
    foreach (ws[i]) begin
      c.bond_skew_wait = ws[i];
      m_run(c, S1, 10'h000, 1'b1);
    end
    en = 1'b0;
    m_run(c0, S1, 10'h000, 1'b0);
    en = 1'b1;
  endtask
  task automatic t_match();
    bond_cfg_t c;
    c = c0;
    m_run(c, S2, 10'h000, 1'b0);
    c.bond_sequence_two_active = 1'b1;
    m_run(c, S2, 10'h000, 1'b1);
    m_run(c0, S1 ^ 10'h200, 10'h000, 1'b1);
    c = c0;
    c.disparity_error_match_on = 1'b1;
    m_run(c, S1 ^ 10'h200, 10'h000, 1'b0);
    c = c0;
    c.bond_data_source_select = 1'b0;
    c.rx_width_10b = 1'b0;
    m_run(c, S1 ^ 10'h100, 10'h000, 1'b1);
    c.rx_width_10b = 1'b1;
    m_run(c, S1 ^ 10'h100, 10'h000, 1'b0);
  endtask
  task automatic t_mask();
    bond_cfg_t c;
    c = c0;
    c.bond_sequence_length = 3'h2;
    c.bond_sequence_one_values[1] = 10'h155;
    c.bond_sequence_one_mask = 4'hD;
    m_run(c, S1, 10'h0AA, 1'b1);
    c.bond_sequence_one_mask = 4'hF;
    m_run(c, S1, 10'h0AA, 1'b0);
  endtask
  // Correction pulse lands on the master's bond cycle; bit 0 priority
  task automatic t_prio();
    logic [5:0] e;
    for (int p = 0; p < 4; p++) begin
      cfg = c0;
      cfg.correction_over_bonding_priority = 1'(p % 2);
      rst();
      send(S1, 6'h10);
      sv = 1'b0;
      repeat (4) step();
      cc.req = 1'b1;
      cc.skip = 1'(p / 2);
      step();
      cc = '0;
      `CHK(outc[CTRL_CC], 1'b1)
      `CHK(outc[CTRL_SKIP], 1'(p / 2))
      `CHK(done, 1'(p % 2 == 0))
      if (p % 2 == 0) `CHK(rdp, 6'h10)
      step();
      e = (p == 2) ? 6'h12 : 6'h10;
      `CHK(done, 1'(p % 2))
      `CHK(rdp, e)
      rd = 1'b0;
      step();
      rd = 1'b1;
      `CHK(rdp, e)
    end
  endtask
  task automatic t_follow();
    int mx;
    ms = 1'b0;
    fs = 1'b1;
    cfg = c0;
    for (int l = 0; l < 4; l++) begin
      lvl = 3'(l);
      fdly = 4'(l);
      mx = l + 1;
      rst();
      send(S1, 6'h20);
      sv = 1'b0;
      fire = 1'b1;
      step();
      fire = 1'b0;
      for (int k = 0; k < 20 && !up_ctrl[CTRL_BOND]; k++) step();
      for (int k = 1; k <= mx; k++) begin
        step();
        if (k == 1) `CHK(outc[CTRL_BOND], 1'b1)
        `CHK(done, 1'(k == mx))
      end
      `CHK(rdp, 6'h20)
    end
    lvl = 3'h0;
  endtask
  task automatic err_is(input logic e);
    step();
    step();
    `CHK(err, e)
  endtask
  task automatic t_cfgerr();
    cfg = c0;
    cfg.rx_internal_width_sel = 1'b1;
    ms = 1'b1;
    fs = 1'b0;
    lvl = 3'h4;
    rst();
    err_is(1'b1);
    lvl = 3'h3;
    err_is(1'b0);
    fs = 1'b1;
    err_is(1'b1);
    fs = 1'b0;
    cfg.bond_skew_wait = 4'h0;
    err_is(1'b1);
  endtask
  initial begin
    c0 = '0;
    c0.bond_sequence_length = 3'h1;
    c0.bond_sequence_one_values[0] = S1;
    c0.bond_sequence_two_values[0] = S2;
    c0.bond_sequence_one_mask = 4'hF;
    c0.bond_sequence_two_mask = 4'hF;
    c0.bond_data_source_select = 1'b1;
    c0.rx_width_10b = 1'b1;
    c0.bond_skew_wait = 4'h3;
    cfg = c0;
    repeat (20) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    t_master();
    t_match();
    t_mask();
    t_prio();
    t_follow();
    t_cfgerr();
    results();
  end
endmodule
